// ### logic/lsc_pkg.sv
// Constants, register map and state types of the low-speed control and status block.
package lsc_pkg;
  localparam int          LANES          = 10;
  localparam int          ADDR_W         = 16;
  localparam int          DATA_W         = 16;
  // Management register offsets.
  localparam logic [15:0] CTL_ASSIGN_0   = 16'ha005;
  localparam logic [15:0] ALARM_SEL_0    = 16'ha008;
  localparam logic [15:0] RETIMER_MODE   = 16'ha015;
  localparam logic [15:0] ALERT_STATUS   = 16'hb000;
  localparam logic [15:0] ALERT_MASK     = 16'hb001;
  localparam logic [15:0] MODULE_STATE   = 16'hb002;
  // Retimer control codes.
  localparam logic [7:0]  RETIMER_BYPASS = 8'h09;
  localparam logic [7:0]  RETIMER_ON     = 8'h01;
  // Alarm source codes for the assignable outputs.
  localparam logic [7:0]  SRC_FULL_POWER = 8'h01;
  localparam logic [7:0]  SRC_READY      = 8'h02;
  localparam logic [7:0]  SRC_FAULT      = 8'h03;
  localparam logic [7:0]  SRC_RX_LOST    = 8'h04;
  // Reset values.
  localparam logic [2:0]  CTL_ASSIGN_RST = 3'h1;
  localparam logic [23:0] ALARM_SEL_RST  = 24'h030201;
  localparam logic [2:0]  MASK_RST       = 3'h0;
  // Alert status bit positions.
  localparam int          ST_TEMP_BIT    = 0;
  localparam int          ST_VCC_BIT     = 1;
  localparam int          ST_LOS_BIT     = 2;
  // Power classes needed in bypass and in retimed operation.
  localparam logic [2:0]  CLASS_BYPASS   = 3'h2;
  localparam logic [2:0]  CLASS_RETIMED  = 3'h3;
  // Timing.
  localparam int          CLK_KHZ        = 100000;
  localparam int          INIT_TIME_MS   = 2500;
  localparam int          INIT_CYCLES    = INIT_TIME_MS * CLK_KHZ;
  // Synchroniser idle values: host pins float to their safe level.
  localparam int          SYNC_W         = 16;
  localparam logic [15:0] SYNC_RST       = 16'h003f;

  typedef enum logic [1:0] {
    ST_INIT,
    ST_LOW_POWER,
    ST_FULL_POWER,
    ST_FAULT
  } mod_state_e;
endpackage

// ### logic/low_speed_ctl.sv
// Low-speed control pins, alert summary and retimer mode of the transceiver module.
`timescale 1ns/1ps
module low_speed_ctl #(
  parameter int unsigned INIT_WAIT = lsc_pkg::INIT_CYCLES
) (
  input  wire logic                       clk_i,
  input  wire logic                       nrst_i,
  input  wire logic                       laser_off_request_i,
  input  wire logic                       reduced_power_request_i,
  input  wire logic                       module_reset_low_i,
  input  wire logic                       assignable_input_one_i,
  input  wire logic                       assignable_input_two_i,
  input  wire logic                       assignable_input_three_i,
  input  wire logic [lsc_pkg::LANES-1:0]  optical_input_lost_i,
  input  wire logic                       temp_alarm_i,
  input  wire logic                       vcc_alarm_i,
  input  wire logic [lsc_pkg::ADDR_W-1:0] mgmt_addr_i,
  input  wire logic [lsc_pkg::DATA_W-1:0] mgmt_wdata_i,
  input  wire logic                       mgmt_wr_i,
  output logic      [lsc_pkg::DATA_W-1:0] mgmt_rdata_o,
  output logic                            laser_enable_o,
  output logic                            optical_input_lost_o,
  output logic                            low_power_mode_o,
  output logic                            retimer_on_o,
  output logic                            lane_chip_reset_low_o,
  output logic                            assignable_output_one_o,
  output logic                            assignable_output_two_o,
  output logic                            assignable_output_three_o,
  output logic                            summary_alert_low_o,
  output logic                            summary_alert_oe_n_o,
  output logic                            port_empty_indication_o
);
  import lsc_pkg::*;

  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic              tx_off_s;
  logic              low_pwr_s;
  logic              mod_rst_n_s;
  logic [2:0]        ctl_pin_s;
  logic [LANES-1:0]  los_s;
  logic              vol_rst;
  mod_state_e        state_q;
  logic [31:0]       init_cnt_q;
  logic [1:0]        interlock_q;
  logic [7:0]        retimer_q;
  logic [2:0]        ctl_assign_q;
  logic [7:0]        alarm_sel_q [3];
  logic [2:0]        status_q;
  logic [2:0]        mask_q;
  logic [2:0]        src;
  logic [2:0]        clr;
  logic              chip_rst;
  logic [2:0]        alarm_bit;
  logic [2:0]        need_class;
  logic              wr_retimer;

  assign async_in = {optical_input_lost_i, assignable_input_three_i, assignable_input_two_i,
                     assignable_input_one_i, module_reset_low_i, reduced_power_request_i,
                     laser_off_request_i};

  // The first stage feeds only the second, so metastability cannot reach logic.
  for (genvar b = 0; b < SYNC_W; b++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
        meta_q[b] <= SYNC_RST[b];
        sync_q[b] <= SYNC_RST[b];
      end else begin
        meta_q[b] <= async_in[b];
        sync_q[b] <= meta_q[b];
      end
    end
  end

  assign tx_off_s    = sync_q[0];
  assign low_pwr_s   = sync_q[1];
  assign mod_rst_n_s = sync_q[2];
  assign ctl_pin_s   = sync_q[5:3];
  assign los_s       = sync_q[SYNC_W-1:6];
  assign vol_rst     = !nrst_i || !mod_rst_n_s;

  // Pins two and three carry the interlock code until initialisation ends.
  always_comb begin
    chip_rst = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (ctl_assign_q[i] && !ctl_pin_s[i] && (i == 0 || state_q != ST_INIT)) begin
        chip_rst = 1'b1;
      end
    end
  end

  assign need_class = (retimer_q == RETIMER_ON) ? CLASS_RETIMED : CLASS_BYPASS;

  always_ff @(posedge clk_i) begin
    if (vol_rst) begin
      state_q     <= ST_INIT;
      init_cnt_q  <= 32'h0;
      interlock_q <= 2'h0;
    end else begin
      case (state_q)
        ST_INIT: begin
          interlock_q <= ctl_pin_s[2:1];
          if (init_cnt_q >= INIT_WAIT - 1) begin
            state_q <= ST_LOW_POWER;
          end else begin
            init_cnt_q <= init_cnt_q + 32'h1;
          end
        end
        ST_LOW_POWER: begin
          if (!low_pwr_s) begin
            state_q <= ({1'b0, interlock_q} + 3'h1 < need_class) ? ST_FAULT : ST_FULL_POWER;
          end
        end
        ST_FULL_POWER: begin
          if (low_pwr_s) begin
            state_q <= ST_LOW_POWER;
          end
        end
        ST_FAULT: begin
          if (low_pwr_s) begin
            state_q <= ST_LOW_POWER;
          end
        end
        default: state_q <= ST_INIT;
      endcase
    end
  end

  assign wr_retimer = mgmt_wr_i && mgmt_addr_i == RETIMER_MODE;

  // A lane chip reset drops the retimers back to bypass, their default.
  always_ff @(posedge clk_i) begin
    if (vol_rst || chip_rst) begin
      retimer_q <= RETIMER_BYPASS;
    end else if (wr_retimer && (mgmt_wdata_i[7:0] == RETIMER_ON ||
                                mgmt_wdata_i[7:0] == RETIMER_BYPASS)) begin
      retimer_q <= mgmt_wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (vol_rst) begin
      ctl_assign_q <= CTL_ASSIGN_RST;
      for (int i = 0; i < 3; i++) begin
        alarm_sel_q[i] <= ALARM_SEL_RST[8*i +: 8];
      end
      mask_q <= MASK_RST;
    end else if (mgmt_wr_i) begin
      for (int i = 0; i < 3; i++) begin
        if (mgmt_addr_i == CTL_ASSIGN_0 + 16'(i)) begin
          ctl_assign_q[i] <= mgmt_wdata_i[0];
        end
        if (mgmt_addr_i == ALARM_SEL_0 + 16'(i)) begin
          alarm_sel_q[i] <= mgmt_wdata_i[7:0];
        end
      end
      if (mgmt_addr_i == ALERT_MASK) begin
        mask_q <= mgmt_wdata_i[2:0];
      end
    end
  end

  assign src = {|los_s, vcc_alarm_i, temp_alarm_i};
  assign clr = (mgmt_wr_i && mgmt_addr_i == ALERT_STATUS) ? mgmt_wdata_i[2:0] : 3'h0;

  // Write one to clear; a source still active in the clear cycle sets the bit again.
  always_ff @(posedge clk_i) begin
    if (vol_rst) begin
      status_q <= 3'h0;
    end else begin
      status_q <= (status_q & ~clr) | src;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      case (alarm_sel_q[i])
        SRC_FULL_POWER: alarm_bit[i] = state_q == ST_FULL_POWER;
        SRC_READY:      alarm_bit[i] = state_q == ST_FULL_POWER || state_q == ST_LOW_POWER;
        SRC_FAULT:      alarm_bit[i] = state_q == ST_FAULT;
        SRC_RX_LOST:    alarm_bit[i] = |los_s;
        default:        alarm_bit[i] = 1'b0;
      endcase
    end
  end

  // Every pin reaches its outputs within four clocks, far inside the timing bounds.
  always_ff @(posedge clk_i) begin
    if (vol_rst) begin
      laser_enable_o          <= 1'b0;
      optical_input_lost_o    <= 1'b0;
      low_power_mode_o        <= 1'b1;
      retimer_on_o            <= 1'b0;
      lane_chip_reset_low_o   <= 1'b0;
      {assignable_output_three_o, assignable_output_two_o, assignable_output_one_o} <= 3'h0;
      summary_alert_low_o     <= 1'b1;
      summary_alert_oe_n_o    <= 1'b1;
    end else begin
      laser_enable_o          <= !tx_off_s && state_q == ST_FULL_POWER;
      optical_input_lost_o    <= |los_s;
      low_power_mode_o        <= state_q != ST_FULL_POWER;
      retimer_on_o            <= retimer_q == RETIMER_ON;
      lane_chip_reset_low_o   <= !chip_rst;
      {assignable_output_three_o, assignable_output_two_o, assignable_output_one_o} <= alarm_bit;
      summary_alert_low_o     <= 1'b0;
      summary_alert_oe_n_o    <= !(|(status_q & ~mask_q));
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      port_empty_indication_o <= 1'b0;
      mgmt_rdata_o            <= 16'h0;
    end else begin
      port_empty_indication_o <= 1'b0;
      case (mgmt_addr_i)
        RETIMER_MODE:         mgmt_rdata_o <= {8'h0, retimer_q};
        CTL_ASSIGN_0:         mgmt_rdata_o <= {15'h0, ctl_assign_q[0]};
        CTL_ASSIGN_0 + 16'h1: mgmt_rdata_o <= {15'h0, ctl_assign_q[1]};
        CTL_ASSIGN_0 + 16'h2: mgmt_rdata_o <= {15'h0, ctl_assign_q[2]};
        ALARM_SEL_0:          mgmt_rdata_o <= {8'h0, alarm_sel_q[0]};
        ALARM_SEL_0 + 16'h1:  mgmt_rdata_o <= {8'h0, alarm_sel_q[1]};
        ALARM_SEL_0 + 16'h2:  mgmt_rdata_o <= {8'h0, alarm_sel_q[2]};
        ALERT_STATUS:         mgmt_rdata_o <= {13'h0, status_q};
        ALERT_MASK:           mgmt_rdata_o <= {13'h0, mask_q};
        MODULE_STATE:         mgmt_rdata_o <= {12'h0, interlock_q, state_q};
        default:              mgmt_rdata_o <= 16'h0;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_retimer_on_write;
    wr_retimer && mgmt_wdata_i[7:0] == RETIMER_ON && !chip_rst && mod_rst_n_s;
  endsequence

  a_laser_off_follow: assert property (tx_off_s |=> !laser_enable_o)
    else $error("laser enabled while disable request high");
  a_los_or_out: assert property (##1 $past(mod_rst_n_s)
                                 |-> optical_input_lost_o == $past(|los_s))
    else $error("receive loss output differs from lane OR");
  a_low_power_hold: assert property (low_pwr_s |=> ##1 low_power_mode_o)
    else $error("full power while low power requested");
  a_module_reset_all: assert property (!mod_rst_n_s |=> retimer_q == RETIMER_BYPASS
                                       && status_q == 3'h0 && state_q == ST_INIT)
    else $error("module reset left volatile state");
  a_alert_drive: assert property (|(status_q & ~mask_q) && mod_rst_n_s |=> !summary_alert_oe_n_o)
    else $error("alert not driven for unmasked flag");
  a_status_set_wins: assert property (src[ST_LOS_BIT] && mod_rst_n_s
                                      |=> status_q[ST_LOS_BIT])
    else $error("loss flag lost against clear");
  a_retimer_enable: assert property (s_retimer_on_write ##1 mod_rst_n_s |=> retimer_on_o)
    else $error("retimer write of on code not applied");
  a_bad_code_kept: assert property (wr_retimer && mgmt_wdata_i[7:0] != RETIMER_ON &&
                                    mgmt_wdata_i[7:0] != RETIMER_BYPASS && !chip_rst &&
                                    mod_rst_n_s |=> $stable(retimer_q))
    else $error("undefined retimer code changed the mode");
  a_chip_reset_pin: assert property (ctl_assign_q[0] && !ctl_pin_s[0] && mod_rst_n_s
                                     |=> !lane_chip_reset_low_o && retimer_q == RETIMER_BYPASS)
    else $error("control pin one did not reset lane chips");
  a_init_bound: assert property (state_q == ST_INIT |-> init_cnt_q < INIT_WAIT)
    else $error("initialisation overran its count");
  a_port_present: assert property (##1 !port_empty_indication_o)
    else $error("presence output not low");
endmodule

// ### verification/host_pins_model.sv
// Host-side model of the module control pins, pull resistors and host readback.
`timescale 1ns/1ps
module host_pins_model (
  input  wire logic release_i,
  input  wire logic want_tx_off_i,
  input  wire logic want_low_pwr_i,
  input  wire logic want_rst_low_i,
  input  wire logic port_empty_indication_i,
  input  wire logic summary_alert_low_i,
  input  wire logic summary_alert_oe_n_i,
  output logic      laser_off_request_o,
  output logic      reduced_power_request_o,
  output logic      module_reset_low_o,
  output logic      host_sees_absent_o,
  output logic      host_sees_alert_o
);
  // A released pin floats to its safe level, as an unconnected host would leave it.
  assign laser_off_request_o     = release_i ? 1'b1 : want_tx_off_i;
  assign reduced_power_request_o = release_i ? 1'b1 : want_low_pwr_i;
  assign module_reset_low_o      = release_i ? 1'b1 : want_rst_low_i;
  // The host pull-ups make the presence and alert lines read high unless pulled down.
  assign host_sees_absent_o      = (port_empty_indication_i === 1'b0) ? 1'b0 : 1'b1;
  assign host_sees_alert_o       = summary_alert_oe_n_i ? 1'b1 : summary_alert_low_i;
endmodule

// ### verification/low_speed_ctl_tb_top.sv
// Self-checking bench of the low-speed control block driven through a host pin model.
`timescale 1ns/1ps
module low_speed_ctl_tb_top;
  import lsc_pkg::*;
  localparam int unsigned INIT_SIM = 20;
  logic              clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic              rel = 1'b0, w_tx = 1'b1, w_lp = 1'b1, w_rst = 1'b1;
  logic              in1 = 1'b1, in2 = 1'b1, in3 = 1'b1, temp = 1'b0, vcc = 1'b0;
  logic [LANES-1:0]  lost = '0;
  logic [15:0]       addr = 16'h0000, wdata = 16'h0000;
  logic              wr = 1'b0;
  logic [15:0]       rdata;
  logic              p_tx, p_lp, p_rst, laser_en, los, lpm, rt_on, lcr_l;
  logic              ao1, ao2, ao3, al_l, al_oe_n, empty, h_absent, h_alert;
  int                fails = 0, cmp_count = 0, cycles = 0;

  always #5 clk_i = ~clk_i;

  host_pins_model host_pins_model_inst (.release_i(rel), .want_tx_off_i(w_tx),
    .want_low_pwr_i(w_lp), .want_rst_low_i(w_rst), .port_empty_indication_i(empty),
    .summary_alert_low_i(al_l), .summary_alert_oe_n_i(al_oe_n), .laser_off_request_o(p_tx),
    .reduced_power_request_o(p_lp), .module_reset_low_o(p_rst),
    .host_sees_absent_o(h_absent), .host_sees_alert_o(h_alert));

  low_speed_ctl #(.INIT_WAIT(INIT_SIM)) low_speed_ctl_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .laser_off_request_i(p_tx), .reduced_power_request_i(p_lp), .module_reset_low_i(p_rst),
    .assignable_input_one_i(in1), .assignable_input_two_i(in2), .assignable_input_three_i(in3),
    .optical_input_lost_i(lost), .temp_alarm_i(temp), .vcc_alarm_i(vcc), .mgmt_addr_i(addr),
    .mgmt_wdata_i(wdata), .mgmt_wr_i(wr), .mgmt_rdata_o(rdata), .laser_enable_o(laser_en),
    .optical_input_lost_o(los), .low_power_mode_o(lpm), .retimer_on_o(rt_on),
    .lane_chip_reset_low_o(lcr_l), .assignable_output_one_o(ao1),
    .assignable_output_two_o(ao2), .assignable_output_three_o(ao3),
    .summary_alert_low_o(al_l), .summary_alert_oe_n_o(al_oe_n),
    .port_empty_indication_o(empty));

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles; a hang ends here.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      $display("BAD timeout expected finish seen hang");
      test_done();
    end
  end

  task automatic chk_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Every drive lands one nanosecond after a rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
    addr = a;
    cyc(1);
    chk_word(what, exp, rdata);
  endtask

  task automatic t_reset_values();
    chk_bit("laser_enable", 1'b0, laser_en);
    chk_bit("low_power_mode", 1'b1, lpm);
    chk_bit("retimer_on", 1'b0, rt_on);
    chk_bit("host_absent", 1'b0, h_absent);
    chk_bit("host_alert", 1'b1, h_alert);
    rd_chk("retimer_mode", RETIMER_MODE, {8'h00, RETIMER_BYPASS});
    rd_chk("ctl_assign_one", CTL_ASSIGN_0, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      rd_chk("alarm_sel", ALARM_SEL_0 + 16'(i), 16'(i + 1));
    end
    rd_chk("alert_mask", ALERT_MASK, {13'h0000, MASK_RST});
    rd_chk("module_state", MODULE_STATE, {12'h000, 2'b11, 2'(ST_LOW_POWER)});
  endtask

  task automatic t_power_and_tx();
    w_lp = 1'b0;
    cyc(5);
    chk_bit("low_power_mode", 1'b0, lpm);
    chk_bit("full_power_out", 1'b1, ao1);
    chk_bit("ready_out", 1'b1, ao2);
    chk_bit("fault_out", 1'b0, ao3);
    chk_bit("laser_enable", 1'b0, laser_en);
    w_tx = 1'b0;
    cyc(3);
    chk_bit("laser_enable", 1'b1, laser_en);
    w_tx = 1'b1;
    cyc(3);
    chk_bit("laser_enable", 1'b0, laser_en);
    w_tx = 1'b0;
    rel = 1'b1;
    cyc(5);
    chk_bit("laser_enable", 1'b0, laser_en);
    chk_bit("low_power_mode", 1'b1, lpm);
    rel = 1'b0;
    cyc(8);
    chk_bit("laser_enable", 1'b1, laser_en);
  endtask

  task automatic t_rx_loss();
    wr_reg(ALARM_SEL_0 + 16'h0002, {8'h00, SRC_RX_LOST});
    for (int i = 0; i < LANES; i++) begin
      lost = LANES'(1) << i;
      cyc(3);
      chk_bit("rx_lost", 1'b1, los);
      chk_bit("rx_lost_out", 1'b1, ao3);
      lost = '0;
      cyc(3);
      chk_bit("rx_lost", 1'b0, los);
      chk_bit("rx_lost_out", 1'b0, ao3);
    end
    chk_bit("host_alert", 1'b0, h_alert);
    rd_chk("alert_status", ALERT_STATUS, 16'h0001 << ST_LOS_BIT);
    wr_reg(ALERT_STATUS, 16'h0001 << ST_LOS_BIT);
    cyc(2);
    chk_bit("host_alert", 1'b1, h_alert);
  endtask

  task automatic t_alarm_mask();
    temp = 1'b1;
    cyc(2);
    chk_bit("host_alert", 1'b0, h_alert);
    rd_chk("alert_status", ALERT_STATUS, 16'h0001 << ST_TEMP_BIT);
    temp = 1'b0;
    wr_reg(ALERT_STATUS, 16'h0001 << ST_TEMP_BIT);
    cyc(2);
    chk_bit("host_alert", 1'b1, h_alert);
    wr_reg(ALERT_MASK, 16'h0001 << ST_VCC_BIT);
    vcc = 1'b1;
    cyc(3);
    rd_chk("alert_status", ALERT_STATUS, 16'h0001 << ST_VCC_BIT);
    chk_bit("host_alert", 1'b1, h_alert);
    wr_reg(ALERT_MASK, 16'h0000);
    cyc(2);
    chk_bit("host_alert", 1'b0, h_alert);
    vcc = 1'b0;
    wr_reg(ALERT_STATUS, 16'h0001 << ST_VCC_BIT);
    cyc(2);
    chk_bit("host_alert", 1'b1, h_alert);
  endtask

  task automatic t_retimer();
    wr_reg(RETIMER_MODE, 16'h0005);
    rd_chk("retimer_mode", RETIMER_MODE, {8'h00, RETIMER_BYPASS});
    chk_bit("retimer_on", 1'b0, rt_on);
    wr_reg(RETIMER_MODE, {8'h00, RETIMER_ON});
    chk_bit("retimer_on", 1'b1, rt_on);
    rd_chk("retimer_mode", RETIMER_MODE, {8'h00, RETIMER_ON});
    wr_reg(16'ha0ff, 16'h1234);
    rd_chk("unmapped", 16'ha0ff, 16'h0000);
    in1 = 1'b0;
    cyc(4);
    chk_bit("lane_chip_reset_low", 1'b0, lcr_l);
    chk_bit("retimer_on", 1'b0, rt_on);
    in1 = 1'b1;
    cyc(4);
    chk_bit("lane_chip_reset_low", 1'b1, lcr_l);
  endtask

  task automatic t_module_reset();
    wr_reg(RETIMER_MODE, {8'h00, RETIMER_ON});
    wr_reg(ALERT_MASK, 16'h0004);
    w_rst = 1'b0;
    cyc(4);
    chk_bit("laser_enable", 1'b0, laser_en);
    rd_chk("retimer_mode", RETIMER_MODE, {8'h00, RETIMER_BYPASS});
    in2 = 1'b0;
    in3 = 1'b0;
    w_rst = 1'b1;
    cyc(INIT_SIM + 10);
    rd_chk("alert_mask", ALERT_MASK, 16'h0000);
    rd_chk("module_state", MODULE_STATE, {12'h000, 2'b00, 2'(ST_FAULT)});
    chk_bit("fault_out", 1'b1, ao3);
    chk_bit("full_power_out", 1'b0, ao1);
    chk_bit("laser_enable", 1'b0, laser_en);
    wr_reg(RETIMER_MODE, {8'h00, RETIMER_ON});
    rd_chk("retimer_mode", RETIMER_MODE, {8'h00, RETIMER_ON});
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    cyc(INIT_SIM + 5);
    t_reset_values();
    t_power_and_tx();
    t_rx_loss();
    t_alarm_mask();
    t_retimer();
    t_module_reset();
    test_done();
  end
endmodule
